// [rtl/fsp_pkg.sv]
// Constants for the flash sector program/protect controller.
// Assumes a 16-bit CPU address space with the flash at its top.
package fsp_pkg;
	// ----------------------------------------------------------------
	// Address map and sector layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] SECTOR_SIZE = 16'h1000;
	localparam logic [15:0] SEC0_BASE = 16'hf000;
	localparam logic [15:0] SEC0_TOP = 16'hffff;
	localparam logic [15:0] SEC1_BASE = 16'he000;
	localparam logic [1:0] SEC_NONE = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] STAT_RESET = 8'h00;
	// Guard unlock key pair, values arbitrary
	localparam logic [7:0] GUARD_KEY1 = 8'h56;
	localparam logic [7:0] GUARD_KEY2 = 8'hae;

	// Programming modes
	typedef enum logic [1:0] {
		FSP_MODE_USER = 2'b00,
		FSP_MODE_TOOL = 2'b01,
		FSP_MODE_ICP = 2'b10,
		FSP_MODE_IAP = 2'b11
	} fsp_mode_e;

	// Commands
	typedef enum logic [1:0] {
		FSP_CMD_PROG = 2'b00,
		FSP_CMD_SECT_ERASE = 2'b01,
		FSP_CMD_MASS_ERASE = 2'b10,
		FSP_CMD_UNPROTECT = 2'b11
	} fsp_cmd_e;
endpackage

// [rtl/fsp_flash_ctrl.sv]
// Flash array access controller: sector map, erase, byte program,
// mode permissions and read-out protection.
// Assumes a synchronous command port on sys_clk and mode pins from
// outside the clock domain.
//
// Behaviour
// - Erase whole array or one sector
// - Program one byte per operation
// - Sector operation leaves other sectors unchanged
// - Programmer mode may alter everything
// - In-circuit mode may alter everything
// - In-application mode never alters sector 0
// - Sector count follows array size
// - Sectors 0,1 are 4K, rest sector 2
// - Sector 0 is F000h to FFFFh
// - Protection blocks external reads and writes
// - Unprotecting first erases entire array
// - Protection follows option bit only
// - Key guard must unlock each operation
`timescale 1ns/1ps
module fsp_flash_ctrl
	import fsp_pkg::*;
#(
	parameter int FLASH_KB = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Mode pins, asynchronous
	input wire logic tool_socket_mode,
	input wire logic in_circuit_comm_mode,
	input wire logic in_application_programming_mode,
	// Guard key writes
	input wire logic guard_wr,
	input wire logic [7:0] guard_data,
	// Command port
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [15:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic cmd_done,
	output logic cmd_refused,
	// Read port
	input wire logic rd_en,
	input wire logic rd_external,
	input wire logic [15:0] rd_addr,
	output logic [7:0] rd_data,
	// Status
	output logic readout_protect_option_bit,
	output logic register_access_guard,
	output logic busy
);
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int DEPTH = FLASH_KB * 1024;
	localparam int AW = $clog2(DEPTH);
	localparam logic [15:0] BASE = 16'(32'h10000 - DEPTH);

	// Array storage, top of address space
	logic [7:0] mem [DEPTH];

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Sector of an address, SEC_NONE if outside array
	function automatic logic [1:0] sector_of(input logic [15:0] a);
		logic [1:0] s;
		s = SEC_NONE;
		if (a >= BASE) begin
			if (a >= SEC0_BASE && a <= SEC0_TOP)
				s = 2'h0;
			else if (a >= SEC1_BASE && DEPTH > int'(SECTOR_SIZE))
				s = 2'h1;
			else if (DEPTH > 2 * int'(SECTOR_SIZE))
				s = 2'h2;
		end
		return s;
	endfunction

	// Whether the current mode may alter a sector
	function automatic logic may_alter(input fsp_mode_e m,
		input logic [1:0] s);
		logic ok;
		ok = 1'b0;
		case (m)
			FSP_MODE_TOOL: ok = 1'b1;
			FSP_MODE_ICP: ok = 1'b1;
			FSP_MODE_IAP: ok = (s != 2'h0);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ----------------------------------------------------------------
	// Mode pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pin_s1, pin_s2;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
		end else begin
			pin_s1 <= {tool_socket_mode, in_circuit_comm_mode,
				in_application_programming_mode};
			pin_s2 <= pin_s1;
		end
	end

	// Mode decode, socket wins over comm over IN_APPLICATION_PROGRAMMING_MODE
	fsp_mode_e mode;
	always_comb begin
		if (pin_s2[2])
			mode = FSP_MODE_TOOL;
		else if (pin_s2[1])
			mode = FSP_MODE_ICP;
		else if (pin_s2[0])
			mode = FSP_MODE_IAP;
		else
			mode = FSP_MODE_USER;
	end

	// ----------------------------------------------------------------
	// Guard, protection and operation state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FSP_ST_IDLE = 2'b00,
		FSP_ST_ERASE = 2'b01,
		FSP_ST_DONE = 2'b10
	} fsp_state_e;

	fsp_state_e state, next_state;
	logic [1:0] guard_stage, next_guard_stage; // Key sequence progress
	logic prot, next_prot; // Option bit copy
	logic clr_prot, next_clr_prot; // Unprotect after erase
	logic [AW-1:0] er_ptr, next_er_ptr; // Erase walker
	logic [AW-1:0] er_end, next_er_end;
	logic done, next_done;
	logic refused, next_refused;
	logic [7:0] rdat, next_rdat;
	logic wr_en; // Array write strobe
	logic [AW-1:0] wr_idx;
	logic [7:0] wr_val;

	logic [1:0] csec;
	logic allowed;
	assign csec = sector_of(cmd_addr);

	// Next-state logic for all control state
	always_comb begin
		next_state = state;
		next_guard_stage = guard_stage;
		next_prot = prot;
		next_clr_prot = clr_prot;
		next_er_ptr = er_ptr;
		next_er_end = er_end;
		next_done = 1'b0;
		next_refused = 1'b0;
		wr_en = 1'b0;
		wr_idx = AW'(cmd_addr - BASE);
		wr_val = cmd_data;
		allowed = 1'b0;
		// Key sequence arms the guard, wrong byte disarms it
		if (guard_wr && state == FSP_ST_IDLE) begin
			if (guard_data == GUARD_KEY1)
				next_guard_stage = 2'h1;
			else if (guard_data == GUARD_KEY2 && guard_stage == 2'h1)
				next_guard_stage = 2'h2;
			else
				next_guard_stage = 2'h0;
		end
		case (state)
			FSP_ST_IDLE: begin
				if (cmd_valid) begin
					next_guard_stage = 2'h0; // One op per unlock
					case (cmd_op)
						FSP_CMD_PROG: begin
							allowed = guard_stage == 2'h2 && !prot &&
								csec != SEC_NONE && may_alter(mode, csec);
							if (allowed) begin
								wr_en = 1'b1;
								next_done = 1'b1;
							end else begin
								next_refused = 1'b1;
							end
						end
						FSP_CMD_SECT_ERASE: begin
							allowed = guard_stage == 2'h2 && !prot &&
								csec != SEC_NONE && may_alter(mode, csec);
							if (allowed) begin
								next_state = FSP_ST_ERASE;
								if (csec == 2'h0) begin
									next_er_ptr = AW'(SEC0_BASE - BASE);
									next_er_end = AW'(DEPTH - 1);
								end else if (csec == 2'h1) begin
									next_er_ptr = AW'(SEC1_BASE - BASE);
									next_er_end = AW'(SEC0_BASE - BASE - 1);
								end else begin
									next_er_ptr = '0;
									next_er_end = AW'(SEC1_BASE - BASE - 1);
								end
							end else begin
								next_refused = 1'b1;
							end
						end
						FSP_CMD_MASS_ERASE: begin
							// Whole array includes sector 0
							allowed = guard_stage == 2'h2 && !prot &&
								may_alter(mode, 2'h0);
							if (allowed) begin
								next_state = FSP_ST_ERASE;
								next_er_ptr = '0;
								next_er_end = AW'(DEPTH - 1);
							end else begin
								next_refused = 1'b1;
							end
						end
						default: begin
							// Option write: clearing protection erases
							// the array first, setting needs no erase
							allowed = guard_stage == 2'h2 &&
								(mode == FSP_MODE_TOOL || mode == FSP_MODE_ICP);
							if (!allowed) begin
								next_refused = 1'b1;
							end else if (cmd_data[0]) begin
								next_prot = 1'b1;
								next_done = 1'b1;
							end else begin
								next_state = FSP_ST_ERASE;
								next_clr_prot = 1'b1;
								next_er_ptr = '0;
								next_er_end = AW'(DEPTH - 1);
							end
						end
					endcase
				end
			end
			FSP_ST_ERASE: begin
				// One byte per clock; protection stays on till the end
				wr_en = 1'b1;
				wr_idx = er_ptr;
				wr_val = ERASED_BYTE;
				next_er_ptr = AW'(er_ptr + 1'b1);
				if (er_ptr == er_end)
					next_state = FSP_ST_DONE;
			end
			FSP_ST_DONE: begin
				if (clr_prot)
					next_prot = 1'b0;
				next_clr_prot = 1'b0;
				next_done = 1'b1;
				next_state = FSP_ST_IDLE;
			end
			default: next_state = FSP_ST_IDLE;
		endcase
	end

	// Read data; external reads of a protected array return zero
	always_comb begin
		next_rdat = rdat;
		if (rd_en) begin
			if (rd_addr < BASE)
				next_rdat = STAT_RESET;
			else if (rd_external && prot)
				next_rdat = STAT_RESET;
			else
				next_rdat = mem[AW'(rd_addr - BASE)];
		end
	end

	// Registers for control state
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= FSP_ST_IDLE;
			guard_stage <= 2'h0;
			prot <= 1'b1; // Safe until option loaded
			clr_prot <= 1'b0;
			er_ptr <= '0;
			er_end <= '0;
			done <= 1'b0;
			refused <= 1'b0;
			rdat <= STAT_RESET;
		end else begin
			state <= next_state;
			guard_stage <= next_guard_stage;
			prot <= next_prot;
			clr_prot <= next_clr_prot;
			er_ptr <= next_er_ptr;
			er_end <= next_er_end;
			done <= next_done;
			refused <= next_refused;
			rdat <= next_rdat;
		end
	end

	// Array write, no reset on storage
	always_ff @(posedge sys_clk) begin
		if (wr_en)
			mem[wr_idx] <= wr_val;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign cmd_ready = (state == FSP_ST_IDLE);
	assign cmd_done = done;
	assign cmd_refused = refused;
	assign rd_data = rdat;
	assign readout_protect_option_bit = prot;
	assign register_access_guard = (guard_stage == 2'h2);
	assign busy = (state != FSP_ST_IDLE);
endmodule

// [verification/fsp_flash_ctrl_asserts.sv]
// Checker for the flash controller command, guard and read ports.
// Assumes binding onto fsp_flash_ctrl; sees its ports only.
`timescale 1ns/1ps
module fsp_flash_ctrl_asserts
	import fsp_pkg::*;
#(
	parameter int FLASH_KB = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Command side
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic cmd_refused,
	// Read and status
	input wire logic rd_en,
	input wire logic rd_external,
	input wire logic [7:0] rd_data,
	input wire logic readout_protect_option_bit,
	input wire logic register_access_guard,
	input wire logic busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Command accepted, and its answer
	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_answer;
		cmd_done || cmd_refused;
	endsequence
	chk_done_pulse: assert property (cmd_done |=> !cmd_done)
		else $error("done wider than one cycle");
	chk_refuse_pulse: assert property (cmd_refused |=> !cmd_refused)
		else $error("refused wider than one cycle");
	chk_one_answer: assert property (!(cmd_done && cmd_refused))
		else $error("done and refused together");
	chk_busy_ready: assert property (busy |-> !cmd_ready)
		else $error("ready while busy");
	chk_guard_needed: assert property (s_take ##0 !register_access_guard
		|=> cmd_refused) else $error("unguarded command ran");
	chk_guard_spent: assert property (s_take |=> !register_access_guard)
		else $error("guard still armed");
	chk_prot_refuse: assert property (s_take ##0 (readout_protect_option_bit
		&& cmd_op != FSP_CMD_UNPROTECT) |=> cmd_refused)
		else $error("write while protected");
	chk_prog_answer: assert property (s_take ##0 (cmd_op == FSP_CMD_PROG)
		|=> s_answer) else $error("program not answered");
	chk_erase_start: assert property (s_take ##0
		(cmd_op == FSP_CMD_SECT_ERASE) |=> (busy || cmd_refused))
		else $error("erase did not start");
	chk_ext_blank: assert property (rd_en && rd_external
		&& readout_protect_option_bit |=> rd_data == 8'h00)
		else $error("protected data leaked");
endmodule

// [verification/fsp_tool_model.sv]
// Programming tool model: unlocks the guard, then issues one command.
// Assumes the bench has set the mode pins beforehand.
`timescale 1ns/1ps
module fsp_tool_model
	import fsp_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Command port
	output logic guard_wr,
	output logic [7:0] guard_data,
	output logic cmd_valid,
	output logic [1:0] cmd_op,
	output logic [15:0] cmd_addr,
	output logic [7:0] cmd_data,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic cmd_refused
);
	initial begin
		guard_wr = 0;
		guard_data = 8'h00;
		cmd_valid = 0;
		cmd_op = 2'h0;
		cmd_addr = 16'h0000;
		cmd_data = 8'h00;
	end
	// Result: 1 done, 2 refused, 0 no answer
	task run(input logic g, input logic [1:0] op, input logic [15:0] a,
		input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge sys_clk) #1;
		if (g) begin
			// Two keys back to back arm the guard
			guard_wr = 1;
			guard_data = GUARD_KEY1;
			@(posedge sys_clk) #1;
			guard_data = GUARD_KEY2;
			@(posedge sys_clk) #1;
			guard_wr = 0;
		end
		cmd_valid = 1;
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		// Hold the request through the edge that sees ready high
		while (cmd_ready !== 1'b1) @(posedge sys_clk) #1;
		@(posedge sys_clk) #1;
		cmd_valid = 0;
		r = 0;
		// Whole-array erase takes a little over 8K cycles
		for (n = 0; n < 9000 && r == 0; n++) begin
			// Answer pulses are sampled once settled after the edge
			if (n > 0) @(posedge sys_clk) #1;
			if (cmd_done === 1'b1) r = 1;
			else if (cmd_refused === 1'b1) r = 2;
		end
	endtask
endmodule

// [verification/flash_sector_program_protect_bench.sv]
// Bench for fsp_flash_ctrl with an 8K array (sectors 0 and 1).
// Assumes fsp_tool_model drives the command port.
`timescale 1ns/1ps
module flash_sector_program_protect_bench
	import fsp_pkg::*;
;
	logic sys_clk = 0, rst_b = 0, rd_en = 0, rd_external = 0;
	logic tool_socket_mode = 0, in_circuit_comm_mode = 0;
	logic in_application_programming_mode = 0;
	logic [15:0] rd_addr = 16'h0000, cmd_addr;
	logic guard_wr, cmd_valid, cmd_ready, cmd_done, cmd_refused, busy;
	logic [7:0] guard_data, cmd_data, rd_data;
	logic [1:0] cmd_op;
	logic readout_protect_option_bit, register_access_guard;
	int num_errors = 0, check_count = 0;
	fsp_flash_ctrl #(.FLASH_KB(8)) dut (.sys_clk, .rst_b, .tool_socket_mode,
		.in_circuit_comm_mode, .in_application_programming_mode, .guard_wr,
		.guard_data, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready,
		.cmd_done, .cmd_refused, .rd_en, .rd_external, .rd_addr, .rd_data,
		.readout_protect_option_bit, .register_access_guard, .busy);
	fsp_tool_model tool (.sys_clk, .guard_wr, .guard_data, .cmd_valid,
		.cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .cmd_done, .cmd_refused);
	initial forever #2.5 sys_clk = ~sys_clk;
	task wrap_up;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("Error at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// Mode pins pass a two-stage synchroniser
	task mode(input logic s, input logic c, input logic a);
		@(posedge sys_clk) #1;
		tool_socket_mode = s;
		in_circuit_comm_mode = c;
		in_application_programming_mode = a;
		repeat (4) @(posedge sys_clk);
	endtask
	task rdc(input logic [15:0] a, input logic x, input logic [7:0] e);
		@(posedge sys_clk) #1;
		rd_en = 1;
		rd_external = x;
		rd_addr = a;
		@(posedge sys_clk) #1;
		rd_en = 0;
		chk(rd_data, e);
	endtask
	task cmd(input logic g, input logic [1:0] op, input logic [15:0] a,
		input logic [7:0] d, input logic [1:0] e);
		logic [1:0] r;
		tool.run(g, op, a, d, r);
		chk({6'h00, r}, {6'h00, e});
	endtask
	task t_protected;
		mode(1, 0, 0);
		cmd(1, FSP_CMD_PROG, SEC0_BASE, 8'h5a, 2);
		rdc(SEC0_BASE, 1, 8'h00);
		cmd(1, FSP_CMD_UNPROTECT, SEC0_BASE, 8'h00, 1);
		chk({7'h00, readout_protect_option_bit}, 8'h00);
		rdc(SEC0_TOP, 1, ERASED_BYTE);
		$display("t_protected done");
	endtask
	task t_program;
		cmd(1, FSP_CMD_PROG, SEC0_BASE, 8'ha5, 1);
		cmd(1, FSP_CMD_PROG, SEC1_BASE, 8'h3c, 1);
		rdc(SEC0_BASE, 0, 8'ha5);
		rdc(SEC1_BASE, 0, 8'h3c);
		cmd(1, FSP_CMD_PROG, 16'hd000, 8'h11, 2);
		cmd(0, FSP_CMD_PROG, 16'hf001, 8'h77, 2);
		rdc(16'hf001, 0, ERASED_BYTE);
		$display("t_program done");
	endtask
	task t_sector;
		mode(0, 1, 0);
		cmd(1, FSP_CMD_SECT_ERASE, SEC1_BASE, 8'h00, 1);
		rdc(SEC1_BASE, 0, ERASED_BYTE);
		rdc(SEC0_BASE, 0, 8'ha5);
		rdc(16'hdfff, 0, 8'h00);
		$display("t_sector done");
	endtask
	task t_in_app;
		mode(0, 0, 1);
		cmd(1, FSP_CMD_PROG, 16'hf002, 8'h12, 2);
		cmd(1, FSP_CMD_MASS_ERASE, SEC0_BASE, 8'h00, 2);
		cmd(1, FSP_CMD_PROG, 16'he001, 8'h34, 1);
		rdc(16'hf002, 0, ERASED_BYTE);
		rdc(16'he001, 0, 8'h34);
		mode(0, 0, 0);
		cmd(1, FSP_CMD_PROG, 16'he002, 8'h01, 2);
		mode(1, 0, 0);
		cmd(1, FSP_CMD_UNPROTECT, SEC0_BASE, 8'h01, 1);
		chk({7'h00, readout_protect_option_bit}, 8'h01);
		cmd(1, FSP_CMD_PROG, 16'he003, 8'h22, 2);
		$display("t_in_app done");
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		chk({4'h0, cmd_ready, busy, readout_protect_option_bit,
			register_access_guard}, 8'h0a);
		#1 rst_b = 1;
		$display("t_reset done");
		t_protected;
		t_program;
		t_sector;
		t_in_app;
		wrap_up;
	end
	// Hang guard, well beyond the two long erases
	initial begin
		#200000;
		num_errors++;
		wrap_up;
	end
endmodule
bind fsp_flash_ctrl fsp_flash_ctrl_asserts #(.FLASH_KB(FLASH_KB)) u_chk (
	.sys_clk, .rst_b, .cmd_valid, .cmd_op, .cmd_ready, .cmd_done,
	.cmd_refused, .rd_en, .rd_external, .rd_data,
	.readout_protect_option_bit, .register_access_guard, .busy);
